// [core/pmc_pkg.sv]
// Package: constants for the power mode controller
package pmc_pkg;
  localparam int PMC_NCH = 8;
  localparam int PMC_NIN = 2;
  // Register byte offsets
  localparam logic [7:0] PMC_OFF_OUT = 8'h00;
  localparam logic [7:0] PMC_OFF_HWCR = 8'h04;
  localparam logic [7:0] PMC_OFF_MAP0 = 8'h08;
  localparam logic [7:0] PMC_OFF_MAP1 = 8'h0c;
  localparam logic [7:0] PMC_OFF_STAT = 8'h10;
  localparam logic [7:0] PMC_OFF_ERR = 8'h14;
  localparam logic [7:0] PMC_OFF_DIAG = 8'h18;
  localparam logic [7:0] PMC_OFF_CMD = 8'h1c;
  // Field positions
  localparam int PMC_ACTIVITY_HOLD_BIT = 0;
  localparam int PMC_SOFT_RESET_COMMAND_BIT = 1;
  localparam int PMC_ST_MODE = 0;
  localparam int PMC_ST_UV = 2;
  localparam int PMC_ST_LOP = 3;
  localparam int PMC_ST_TER = 4;
  localparam int PMC_ST_DIAG = 5;
  // Reset values
  localparam logic [7:0] PMC_OUT_RST = 8'h00;
  localparam logic [7:0] PMC_MAP0_RST = 8'h04;
  localparam logic [7:0] PMC_MAP1_RST = 8'h08;
  // Mode field codes
  localparam logic [1:0] PMC_MODE_LIMP = 2'h1;
  localparam logic [1:0] PMC_MODE_ACT = 2'h2;
  localparam logic [1:0] PMC_MODE_IDLE = 2'h3;
  localparam logic [1:0] PMC_MODE_SLEEP = 2'h0;
  localparam logic [7:0] PMC_LIMP_CH = 8'h0c;
  typedef enum logic [3:0] {
    PMC_SLEEP = 4'h1,
    PMC_IDLE = 4'h2,
    PMC_ACTIVE = 4'h4,
    PMC_LIMP = 4'h8
  } pmc_state_type;
endpackage

// [core/pmc_sync.sv]
// Two-flop synchroniser for asynchronous pin and supply levels
`timescale 1ns/100ps
module pmc_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      q_o <= '0;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule // pmc_sync

// [core/pmc_ctrl.sv]
// Power mode controller with Wishbone register file
//
// Our own choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/100ps
// Contract
// - Sleep: outputs off, registers at reset; code resets only OUT, HWCR, MAP0 and MAP1, flags keep their values
// - Power-up needs supply and pin high
// - Power-on when analog or digital good
// - Idle disables diagnosis
// - Idle keeps all channels off
// - Idle with digital supply accepts access
// - Idle preserves channel error flags
// - Idle high plus demand enters Active
// - No hold: no demand returns to Idle
// - Hold bit keeps Active
// - Digital undervoltage to Idle if inputs low
// - Any input enters Active despite mapping
// - Idle low with input: Limp Home
// - Limp Home: reads answered, writes ignored
// - Limp entry sets both supply flags
// - Limp mode field reads 01
// - First command in Limp sets error flag
// - Limp clears open-load-off bits
// - Limp keeps error and monitor bits
// - Limp holds other registers at default
// - Limp drives only channels 2 and 3
// - Reset command keeps channel error flags
// - Undervoltage flag clears after diag readout
module pmc_ctrl import pmc_pkg::*; #(
  parameter int NCH = PMC_NCH
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  output logic err_o,
  input wire logic idle_pin_i,
  input wire logic [PMC_NIN-1:0] parallel_input_pin_i,
  input wire logic vs_present_i,
  input wire logic vs_op_good_i,
  input wire logic vdd_present_i,
  input wire logic vdd_lop_good_i,
  input wire logic vdd_uv_i,
  input wire logic [NCH-1:0] channel_fault_i,
  input wire logic [NCH-1:0] open_load_i,
  input wire logic [NCH-1:0] output_status_i,
  output logic [NCH-1:0] channel_en_o,
  output logic [1:0] mode_o,
  output logic power_on_o,
  output logic diag_en_o
);
  logic [7:0] sync_in;
  logic [7:0] sync_out;
  logic idle_s, vs_pres_s, vs_op_s, vdd_pres_s, vdd_lop_s, vdd_uv_s;
  logic [PMC_NIN-1:0] in_s;
  assign sync_in = {idle_pin_i, parallel_input_pin_i, vs_present_i,
                    vs_op_good_i, vdd_present_i, vdd_lop_good_i, vdd_uv_i};
  pmc_sync #(.W(8)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(sync_in),
    .q_o(sync_out)
  );
  assign {idle_s, in_s, vs_pres_s, vs_op_s, vdd_pres_s, vdd_lop_s,
          vdd_uv_s} = sync_out;

  pmc_state_type state_q, state_d;
  logic [NCH-1:0] channel_on_bit_q;
  logic activity_hold_bit_q;
  logic [7:0] input_map_first_q, input_map_second_q;
  logic analog_undervoltage_flag_q, digital_low_power_flag_q;
  logic transmission_error_flag_q, ter_armed_q;
  logic [NCH-1:0] channel_error_flag_q, open_load_off_diag_q;
  logic ack_q, err_q;
  logic [31:0] rdat_q;

  wire any_in = |in_s;
  wire supply = vs_pres_s | vdd_pres_s;
  wire power_up = supply & (any_in | idle_s);
  wire por = vs_op_s | vdd_lop_s;
  wire demand = any_in | (|channel_on_bit_q);
  wire in_limp = (state_q == PMC_LIMP);
  wire in_active = (state_q == PMC_ACTIVE);
  wire in_sleep = (state_q == PMC_SLEEP);
  wire limp_entry = (state_d == PMC_LIMP) && !in_limp;
  // Registers clear when not in a mode that keeps them
  wire reg_clr = in_sleep | in_limp | !idle_s | !vdd_pres_s;
  wire req = cyc_i & stb_i & ~ack_q & ~err_q;
  wire wr_ok = req & we_i & sel_i[0] & vdd_pres_s & !in_limp;
  wire adr_hit = (adr_i <= PMC_OFF_CMD) && (adr_i[1:0] == 2'h0);
  wire wr_out = wr_ok && adr_i == PMC_OFF_OUT;
  wire wr_hwcr = wr_ok && adr_i == PMC_OFF_HWCR;
  wire wr_map0 = wr_ok && adr_i == PMC_OFF_MAP0;
  wire wr_map1 = wr_ok && adr_i == PMC_OFF_MAP1;
  wire soft_reset_command_bit = wr_hwcr && dat_i[PMC_SOFT_RESET_COMMAND_BIT];
  wire rd_diag = req && !we_i && adr_i == PMC_OFF_DIAG;
  wire any_cmd = req & adr_hit;

  // Mode selection, reevaluated every cycle
  always_comb begin
    state_d = state_q;
    case (state_q)
      PMC_SLEEP: begin
        if (power_up && por) begin
          state_d = idle_s ? PMC_IDLE : PMC_LIMP;
        end
      end
      PMC_IDLE: begin
        if (!idle_s) begin
          state_d = any_in ? PMC_LIMP : PMC_SLEEP;
        end else if (demand && !(vdd_uv_s && !any_in)) begin
          state_d = PMC_ACTIVE;
        end
      end
      PMC_ACTIVE: begin
        if (!idle_s) begin
          state_d = any_in ? PMC_LIMP : PMC_SLEEP;
        end else if (vdd_uv_s && !any_in) begin
          state_d = PMC_IDLE;
        end else if (!activity_hold_bit_q && !demand) begin
          state_d = PMC_IDLE;
        end
      end
      PMC_LIMP: begin
        if (idle_s) begin
          state_d = demand ? PMC_ACTIVE : PMC_IDLE;
        end else if (!any_in) begin
          state_d = PMC_SLEEP;
        end
      end
      default: state_d = PMC_SLEEP;
    endcase
    if (!supply) begin
      state_d = PMC_SLEEP;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= PMC_SLEEP;
    end else begin
      state_q <= state_d;
    end
  end

  // Control registers
  always_ff @(posedge clk_i) begin
    if (rst_i || reg_clr || soft_reset_command_bit) begin
      channel_on_bit_q <= PMC_OUT_RST;
      activity_hold_bit_q <= 1'b0;
      input_map_first_q <= PMC_MAP0_RST;
      input_map_second_q <= PMC_MAP1_RST;
    end else begin
      if (wr_out) channel_on_bit_q <= dat_i[NCH-1:0];
      if (wr_hwcr) activity_hold_bit_q <= dat_i[PMC_ACTIVITY_HOLD_BIT];
      if (wr_map0) input_map_first_q <= dat_i[7:0];
      if (wr_map1) input_map_second_q <= dat_i[7:0];
    end
  end

  // Supply flags: entry sets win over every clear but the reset input
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      analog_undervoltage_flag_q <= 1'b0;
      digital_low_power_flag_q <= 1'b0;
    end else if (limp_entry) begin
      analog_undervoltage_flag_q <= 1'b1;
      digital_low_power_flag_q <= 1'b1;
    end else begin
      if (!in_sleep && !vs_op_s) begin
        analog_undervoltage_flag_q <= 1'b1;
      end else if (soft_reset_command_bit || rd_diag) begin
        analog_undervoltage_flag_q <= 1'b0;
      end
      if (!in_sleep && !vdd_lop_s) begin
        digital_low_power_flag_q <= 1'b1;
      end else if (soft_reset_command_bit || rd_diag) begin
        digital_low_power_flag_q <= 1'b0;
      end
    end
  end

  // Transmission error: armed on Limp entry, set by first command
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ter_armed_q <= 1'b0;
      transmission_error_flag_q <= 1'b0;
    end else begin
      if (limp_entry) begin
        ter_armed_q <= 1'b1;
      end else if (any_cmd && in_limp) begin
        ter_armed_q <= 1'b0;
      end
      if (any_cmd && in_limp && ter_armed_q) begin
        transmission_error_flag_q <= 1'b1;
      end else if (req && !adr_hit) begin
        transmission_error_flag_q <= 1'b1;
      end else if (req && !we_i && adr_i == PMC_OFF_STAT) begin
        transmission_error_flag_q <= 1'b0;
      end
    end
  end

  // Diagnosis flags; error flags survive everything but reset input and a write of ones to the error register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      channel_error_flag_q <= '0;
      open_load_off_diag_q <= '0;
    end else begin
      channel_error_flag_q <= (channel_error_flag_q
        & ~((wr_ok && adr_i == PMC_OFF_ERR) ? dat_i[NCH-1:0] : '0))
        | (in_sleep ? '0 : channel_fault_i);
      if (in_limp) begin
        open_load_off_diag_q <= '0;
      end else if (diag_en_o) begin
        open_load_off_diag_q <= open_load_off_diag_q
          | (open_load_i & ~channel_en_o);
      end else if (rd_diag) begin
        open_load_off_diag_q <= '0;
      end
    end
  end

  // Channel drive
  wire [7:0] map_in0 = in_s[0] ? input_map_first_q : 8'h00;
  wire [7:0] map_in1 = in_s[1] ? input_map_second_q : 8'h00;
  wire [7:0] limp_ch = {4'h0, in_s[1], in_s[0], 2'h0} & PMC_LIMP_CH;
  logic [NCH-1:0] ch_d;
  always_comb begin
    ch_d = '0;
    if (in_active) begin
      ch_d = channel_on_bit_q | map_in0[NCH-1:0] | map_in1[NCH-1:0];
    end else if (in_limp) begin
      ch_d = limp_ch[NCH-1:0];
    end
  end

  logic [1:0] mode_d;
  always_comb begin
    case (state_q)
      PMC_LIMP: mode_d = PMC_MODE_LIMP;
      PMC_ACTIVE: mode_d = PMC_MODE_ACT;
      PMC_IDLE: mode_d = PMC_MODE_IDLE;
      default: mode_d = PMC_MODE_SLEEP;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      channel_en_o <= '0;
      mode_o <= PMC_MODE_SLEEP;
      power_on_o <= 1'b0;
      diag_en_o <= 1'b0;
    end else begin
      channel_en_o <= ch_d;
      mode_o <= mode_d;
      power_on_o <= por;
      diag_en_o <= (state_d == PMC_ACTIVE);
    end
  end

  // Wishbone read mux
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (adr_i)
      PMC_OFF_OUT: rd_mux[NCH-1:0] = channel_on_bit_q;
      PMC_OFF_HWCR: rd_mux[PMC_ACTIVITY_HOLD_BIT] = activity_hold_bit_q;
      PMC_OFF_MAP0: rd_mux[7:0] = input_map_first_q;
      PMC_OFF_MAP1: rd_mux[7:0] = input_map_second_q;
      PMC_OFF_STAT: rd_mux[5:0] = {diag_en_o, transmission_error_flag_q,
        digital_low_power_flag_q, analog_undervoltage_flag_q, mode_o};
      PMC_OFF_ERR: rd_mux[NCH-1:0] = channel_error_flag_q;
      PMC_OFF_DIAG: rd_mux[NCH-1:0] = open_load_off_diag_q;
      PMC_OFF_CMD: rd_mux[NCH-1:0] = output_status_i;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req & adr_hit;
      err_q <= req & ~adr_hit;
      if (req) rdat_q <= rd_mux;
    end
  end
  assign ack_o = ack_q;
  assign err_o = err_q;
  assign dat_o = rdat_q;

  a_sleep_off: assert property (
    @(posedge clk_i) disable iff (rst_i)
    in_sleep |=> channel_en_o == '0)
    else $error("channel on in sleep");
  a_idle_nodiag: assert property (
    @(posedge clk_i) disable iff (rst_i)
    state_q == PMC_IDLE && state_d == PMC_IDLE |=> !diag_en_o)
    else $error("diag in idle");
  a_idle_off: assert property (
    @(posedge clk_i) disable iff (rst_i)
    state_q == PMC_IDLE |=> channel_en_o == '0)
    else $error("channel on in idle");
  a_idle_active: assert property (
    @(posedge clk_i) disable iff (rst_i)
    state_q == PMC_IDLE && idle_s && supply && any_in |=> in_active)
    else $error("no active entry");
  a_hold_active: assert property (
    @(posedge clk_i) disable iff (rst_i)
    in_active && activity_hold_bit_q && idle_s && supply && !vdd_uv_s
    |=> in_active)
    else $error("left active under hold");
  a_limp_nowrite: assert property (
    @(posedge clk_i) disable iff (rst_i)
    in_limp && req && we_i && adr_i == PMC_OFF_OUT
    |=> $stable(channel_on_bit_q))
    else $error("write in limp");
  a_limp_flags: assert property (
    @(posedge clk_i) disable iff (rst_i)
    limp_entry |=> analog_undervoltage_flag_q && digital_low_power_flag_q)
    else $error("limp flags not set");
  a_limp_mode: assert property (
    @(posedge clk_i) disable iff (rst_i)
    in_limp && $past(in_limp) |=> mode_o == PMC_MODE_LIMP)
    else $error("bad limp mode");
  a_limp_chan: assert property (
    @(posedge clk_i) disable iff (rst_i)
    in_limp |=> (channel_en_o & ~PMC_LIMP_CH[NCH-1:0]) == '0)
    else $error("wrong limp channel");
  a_limp_open_load_off_diag: assert property (
    @(posedge clk_i) disable iff (rst_i)
    in_limp |=> open_load_off_diag_q == '0)
    else $error("open_load_off_diag in limp");
  a_limp_ter: assert property (
    @(posedge clk_i) disable iff (rst_i)
    in_limp && ter_armed_q && any_cmd |=> transmission_error_flag_q)
    else $error("no error flag on first limp command");
  a_rst_flags: assert property (
    @(posedge clk_i) disable iff (rst_i)
    soft_reset_command_bit && vs_op_s && vdd_lop_s && !limp_entry
    |=> !analog_undervoltage_flag_q && !digital_low_power_flag_q)
    else $error("supply flags kept by reset command");
  c_active: cover property (@(posedge clk_i) in_active);
  c_limp: cover property (@(posedge clk_i) in_limp && any_cmd);
  c_back_idle: cover property (@(posedge clk_i)
    in_active ##1 state_q == PMC_IDLE);
  c_uv_idle: cover property (@(posedge clk_i)
    in_active && vdd_uv_s ##1 state_q == PMC_IDLE);
endmodule // pmc_ctrl

// [testbench/pmc_pin_host.sv]
// Host-side pin driver for idle and parallel input pins
`timescale 1ns/100ps
module pmc_pin_host import pmc_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic idle_req_i,
  input wire logic [PMC_NIN-1:0] in_req_i,
  output logic idle_pin_o,
  output logic [PMC_NIN-1:0] in_pin_o,
  output logic settled_o
);
  logic [2:0] cnt_q;
  logic chg;
  assign chg = (idle_pin_o != idle_req_i) || (in_pin_o != in_req_i);
  always_ff @(posedge clk_i) begin
    idle_pin_o <= idle_req_i;
    in_pin_o <= in_req_i;
  end
  // Quiet time after a pin move before bus traffic
  always_ff @(posedge clk_i) begin
    if (rst_i || chg) begin
      cnt_q <= 3'h6;
    end else if (cnt_q != 3'h0) begin
      cnt_q <= cnt_q - 3'h1;
    end
  end
  assign settled_o = (cnt_q == 3'h0);
endmodule // pmc_pin_host

// [testbench/pmc_ctrl_tb_top.sv]
// Self-checking bench for the power mode controller
`timescale 1ns/100ps
module pmc_ctrl_tb_top import pmc_pkg::*;;
  localparam logic [31:0] m_uv = 32'h1 << PMC_ST_UV;
  localparam logic [31:0] m_lop = 32'h1 << PMC_ST_LOP;
  localparam logic [31:0] m_ter = 32'h1 << PMC_ST_TER;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, rd;
  logic we = 1'b0, cyc = 1'b0, stb = 1'b0;
  logic [3:0] sel = 4'h0;
  logic ack, err, last_err, idle_pin, settled, pwr, den;
  logic idle_req = 1'b0;
  logic [1:0] in_pin, mode;
  logic [1:0] in_req = 2'h0;
  logic vs_pres = 1'b1, vs_ok = 1'b1, vdd_pres = 1'b1;
  logic vdd_ok = 1'b1, vdd_uv = 1'b0;
  logic [7:0] fault = 8'h00, oload = 8'h00, ostat = 8'h00;
  logic [7:0] chen;
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  always #25 clk = ~clk;
  pmc_ctrl u_pmc_ctrl (.clk_i(clk), .rst_i(rst), .adr_i(adr),
    .dat_i(wdat), .dat_o(rdat), .we_i(we), .sel_i(sel), .cyc_i(cyc),
    .stb_i(stb), .ack_o(ack), .err_o(err), .idle_pin_i(idle_pin),
    .parallel_input_pin_i(in_pin), .vs_present_i(vs_pres),
    .vs_op_good_i(vs_ok), .vdd_present_i(vdd_pres),
    .vdd_lop_good_i(vdd_ok), .vdd_uv_i(vdd_uv), .channel_fault_i(fault),
    .open_load_i(oload), .output_status_i(ostat), .channel_en_o(chen),
    .mode_o(mode), .power_on_o(pwr), .diag_en_o(den));
  pmc_pin_host u_pmc_pin_host (.clk_i(clk), .rst_i(rst),
    .idle_req_i(idle_req), .in_req_i(in_req), .idle_pin_o(idle_pin),
    .in_pin_o(in_pin), .settled_o(settled));
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, e, input string s);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, s, g, e);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && err !== 1'b1 && n < 40);
    rd = rdat;
    last_err = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 40) begin
      num_errors++;
      $display("mismatch at %0t: no bus answer", $time);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, e,
                     input string s);
    wb(1'b0, a, 32'h0);
    chk(rd & m, e, s);
  endtask
  task automatic wt;
    repeat (5) @(posedge clk);
  endtask
  task automatic pins(input logic i, input logic [1:0] p);
    int n;
    n = 0;
    @(posedge clk);
    idle_req <= i;
    in_req <= p;
    repeat (3) @(posedge clk);
    while (settled !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    if (n >= 40) begin
      num_errors++;
      $display("mismatch at %0t: pins not settled", $time);
    end
  endtask
  task automatic st(input logic [1:0] e, input logic [7:0] c, input string s);
    chk({30'h0, mode}, {30'h0, e}, s);
    chk({24'h0, chen}, {24'h0, c}, s);
  endtask
  task automatic pulse_fault(input logic [7:0] f);
    @(posedge clk);
    fault <= f;
    wt;
    fault <= 8'h00;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      num_errors++;
      $display("mismatch at %0t: timeout", $time);
      complete_run;
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    wb(1'b1, PMC_OFF_OUT, 32'hff);
    rdc(PMC_OFF_OUT, 32'hff, 32'h0, "sleep out");
    st(PMC_MODE_SLEEP, 8'h00, "sleep");
    $display("test sleep done");
    pins(1'b1, 2'h0);
    st(PMC_MODE_IDLE, 8'h00, "idle");
    chk({31'h0, pwr}, 32'h1, "power on");
    chk({31'h0, den}, 32'h0, "diag off");
    wb(1'b1, PMC_OFF_MAP0, 32'h33);
    rdc(PMC_OFF_MAP0, 32'hff, 32'h33, "map0 rw");
    rdc(PMC_OFF_MAP1, 32'hff, {24'h0, PMC_MAP1_RST}, "map1");
    wb(1'b0, 8'h20, 32'h0);
    chk({31'h0, last_err}, 32'h1, "unmapped");
    wb(1'b1, PMC_OFF_OUT, 32'h01);
    wt;
    st(PMC_MODE_ACT, 8'h01, "out on");
    chk({31'h0, den}, 32'h1, "diag on");
    wb(1'b1, PMC_OFF_OUT, 32'h00);
    wt;
    st(PMC_MODE_IDLE, 8'h00, "out off");
    wb(1'b1, PMC_OFF_OUT, 32'h01);
    wb(1'b1, PMC_OFF_HWCR, 32'h01);
    wb(1'b1, PMC_OFF_OUT, 32'h00);
    wt;
    st(PMC_MODE_ACT, 8'h00, "hold");
    pulse_fault(8'h02);
    wb(1'b1, PMC_OFF_HWCR, 32'h00);
    wt;
    st(PMC_MODE_IDLE, 8'h00, "hold off");
    rdc(PMC_OFF_ERR, 32'h02, 32'h02, "err idle");
    vs_ok <= 1'b0;
    wt;
    chk({31'h0, pwr}, 32'h1, "power on vdd");
    vs_ok <= 1'b1;
    wt;
    rdc(PMC_OFF_STAT, m_uv, m_uv, "uv set");
    wb(1'b1, PMC_OFF_HWCR, 32'h02);
    wt;
    rdc(PMC_OFF_ERR, 32'h02, 32'h02, "err kept");
    rdc(PMC_OFF_MAP0, 32'hff, {24'h0, PMC_MAP0_RST}, "map0 rst");
    rdc(PMC_OFF_STAT, m_uv | m_lop, 32'h0, "flags rst");
    $display("test idle active done");
    oload <= 8'hff;
    wb(1'b1, PMC_OFF_MAP0, 32'h00);
    wb(1'b1, PMC_OFF_MAP1, 32'h00);
    pins(1'b1, 2'h1);
    st(PMC_MODE_ACT, 8'h00, "no map");
    wb(1'b1, PMC_OFF_HWCR, 32'h01);
    pins(1'b1, 2'h0);
    st(PMC_MODE_ACT, 8'h00, "pins low hold");
    vdd_uv <= 1'b1;
    wt;
    st(PMC_MODE_IDLE, 8'h00, "vdd uv");
    vdd_uv <= 1'b0;
    wt;
    wb(1'b1, PMC_OFF_HWCR, 32'h02);
    $display("test map uv done");
    ostat <= 8'h5a;
    pins(1'b0, 2'h2);
    st(PMC_MODE_LIMP, 8'h08, "limp");
    rdc(PMC_OFF_OUT, 32'hff, 32'h0, "limp out");
    rdc(PMC_OFF_STAT, 32'h1f, 32'h1d, "limp st");
    rdc(PMC_OFF_STAT, m_ter, 32'h0, "ter");
    wb(1'b1, PMC_OFF_OUT, 32'hff);
    rdc(PMC_OFF_OUT, 32'hff, 32'h0, "limp wr");
    st(PMC_MODE_LIMP, 8'h08, "limp ch");
    rdc(PMC_OFF_MAP0, 32'hff, {24'h0, PMC_MAP0_RST}, "limp map");
    rdc(PMC_OFF_DIAG, 32'hff, 32'h0, "open_load_off_diag");
    rdc(PMC_OFF_CMD, 32'hff, 32'h5a, "osm");
    pulse_fault(8'h04);
    rdc(PMC_OFF_ERR, 32'h04, 32'h04, "limp err");
    $display("test limp done");
    pins(1'b1, 2'h0);
    st(PMC_MODE_IDLE, 8'h00, "exit");
    vs_ok <= 1'b0;
    wt;
    vs_ok <= 1'b1;
    wt;
    rdc(PMC_OFF_STAT, m_uv, m_uv, "uv held");
    wb(1'b0, PMC_OFF_DIAG, 32'h0);
    rdc(PMC_OFF_STAT, m_uv, 32'h0, "uv clr");
    $display("test uv readout done");
    complete_run;
  end
endmodule // pmc_ctrl_tb_top
